//--- include/irq_ctrl_pkg.sv
// Purpose: Shared constants for the interrupt request and enable logic
// Assumes: Nine sources, four-bit data access from the CPU core
// Notes:   Flag indices double as bit-instruction addresses
package irq_ctrl_pkg;

    // Source indices in the request and enable flag vectors
    localparam int NUM_SRC  = 9;
    localparam int SRC_BT   = 0;
    localparam int SRC_EXT4 = 1;
    localparam int SRC_EXT0 = 2;
    localparam int SRC_EXT1 = 3;
    localparam int SRC_CSI  = 4;
    localparam int SRC_T0   = 5;
    localparam int SRC_TPG  = 6;
    localparam int SRC_EXT2 = 7;
    localparam int SRC_W    = 8;

    // Vector numbers, 1 has the highest priority
    localparam logic [2:0] VEC_NONE = 3'h0;
    localparam logic [2:0] VEC_BT4  = 3'h1;
    localparam logic [2:0] VEC_EXT0 = 3'h2;
    localparam logic [2:0] VEC_EXT1 = 3'h3;
    localparam logic [2:0] VEC_CSI  = 3'h4;
    localparam logic [2:0] VEC_T0   = 3'h5;
    localparam logic [2:0] VEC_TPG  = 3'h6;
    localparam int         VEC_LAST = 6;

    // Nibble addresses of the four-bit access port
    localparam logic [3:0] NIB_IRQ_BASE = 4'h0;
    localparam logic [3:0] NIB_IE_BASE  = 4'h4;
    localparam logic [3:0] NIB_IM0      = 4'h8;
    localparam logic [3:0] NIB_IM1      = 4'h9;
    localparam logic [3:0] NIB_IM2      = 4'ha;
    localparam logic [3:0] NIB_IPS      = 4'hb;

    // Bit-instruction addresses: request flags from 0, enables from here
    localparam logic [4:0] BIT_IE_BASE = 5'h10;

    // Register fields and reset values
    localparam int         IM0_SCLK_BIT = 3;
    localparam int         IPS_IME_BIT  = 3;
    localparam logic [3:0] IM_RST       = 4'h0;
    localparam logic [3:0] IPS_RST      = 4'h0;

    // Edge selection codes
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;

    // Consecutive equal samples needed to pass the noise filter
    localparam int FILT_SAMPLES = 2;

    typedef enum logic [1:0] {BOP_SET, BOP_CLR, BOP_TCLR, BOP_TEST} bit_op_e;

endpackage

//--- include/ext0_filter_if.sv
// Purpose: Carrier between the controller and the ext0 noise filter
// Assumes: One clock domain
// Notes:   Sample tick already gated by standby
`timescale 1ns/1ps
interface ext0_filter_if;
    logic sample_tick;
    logic raw;
    logic clean;
    modport ctrl (output sample_tick, output raw, input clean);
    modport filt (input sample_tick, input raw, output clean);
endinterface

//--- hw/ext0_noise_filter.sv
// Purpose: Sampled noise eliminator for the ext0 pin
// Assumes: Pin synchronous to clk_sys_i
// Notes:   Output changes only after NSAMP equal samples
`timescale 1ns/1ps
module ext0_noise_filter
    import irq_ctrl_pkg::*;
#(
    parameter int NSAMP = FILT_SAMPLES
)
(
    // Clock and reset
    input  wire logic   clk_sys_i,
    input  wire logic   rst_n_i,
    input  wire logic   ce_i,
    // Filter link
    ext0_filter_if.filt flt
);

    typedef struct packed {
        logic [NSAMP-1:0] hist;
        logic             clean;
    } filt_state_s;

    filt_state_s s_q;
    filt_state_s s_d;

    always_comb
    begin
        s_d = s_q;
        if (flt.sample_tick)
        begin
            s_d.hist = {s_q.hist[NSAMP-2:0], flt.raw};
            if (&s_d.hist)
                s_d.clean = 1'b1;
            else if (~|s_d.hist)
                s_d.clean = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            s_q <= '0;
        else if (ce_i)
            s_q <= s_d;
    end

    assign flt.clean = s_q.clean;

endmodule // ext0_noise_filter

//--- hw/irq_request_enable.sv
// Purpose: Interrupt request and enable flags with vectored requests
// Assumes: CPU core drives bit and nibble ports synchronously
// Notes:   Request, accept and flag updates all share clk_sys_i
`timescale 1ns/1ps
module irq_request_enable
    import irq_ctrl_pkg::*;
#(
    parameter int NKEY = 8
)
(
    // Clock, reset, enable
    input  wire logic            clk_sys_i,
    input  wire logic            rst_n_i,
    input  wire logic            ce_i,
    // Internal source events, one-cycle pulses
    input  wire logic            bt_tick_i,
    input  wire logic            serial_done_i,
    input  wire logic            timer_match_i,
    input  wire logic            pulse_gen_match_i,
    input  wire logic            watch_tick_i,
    // External pins
    input  wire logic            ext_irq_pin0_i,
    input  wire logic            ext_irq_pin1_i,
    input  wire logic            ext_irq_pin2_i,
    input  wire logic            ext_irq_pin4_i,
    input  wire logic [NKEY-1:0] key_input_i,
    // Ext0 sampling clocks and standby
    input  wire logic            cpu_clk_tick_i,
    input  wire logic            fx_div64_tick_i,
    input  wire logic            standby_i,
    // CPU sequencer
    input  wire logic [1:0]      nest_status_i,
    input  wire logic            global_enable_op_i,
    input  wire logic            global_disable_op_i,
    input  wire logic            irq_accept_i,
    // Bit instruction port
    input  wire logic            bit_op_valid_i,
    input  wire bit_op_e         bit_op_i,
    input  wire logic [4:0]      bit_addr_i,
    output logic                 bit_value_o,
    output logic                 skip_o,
    // Nibble port
    input  wire logic            nib_wr_i,
    input  wire logic            nib_rd_i,
    input  wire logic [3:0]      nib_addr_i,
    input  wire logic [3:0]      nib_wdata_i,
    output logic [3:0]           nib_rdata_o,
    // Requests to the CPU
    output logic                 vectored_request_o,
    output logic [2:0]           vector_num_o,
    output logic                 wake_o,
    output logic                 master_irq_enable_o
);

    typedef struct packed {
        logic [NUM_SRC-1:0] irq;
        logic [NUM_SRC-1:0] ie;
        logic [3:0]         im0;
        logic [3:0]         im1;
        logic [3:0]         im2;
        logic [3:0]         interrupt_priority_select;
        logic               ext0_prev;
        logic               ext1_prev;
        logic               ext2_prev;
        logic               ext4_prev;
        logic               key_prev;
        logic               bit_val;
        logic               skip;
        logic               vec_req;
        logic [2:0]         vec;
        logic               wake;
        logic [3:0]         rdata;
    } ctl_state_s;

    ctl_state_s s_q;
    ctl_state_s s_d;

    ext0_filter_if flt_if ();

    ext0_noise_filter #(
        .NSAMP (FILT_SAMPLES)
    ) u_filter (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .ce_i      (ce_i),
        .flt       (flt_if.filt)
    );

    function automatic logic edge_hit(input logic [1:0] mode,
                                      input logic       prev,
                                      input logic       cur);
        case (mode)
            EDGE_RISE: edge_hit = cur & ~prev;
            EDGE_FALL: edge_hit = prev & ~cur;
            EDGE_BOTH: edge_hit = prev ^ cur;
            default:   edge_hit = 1'b0;
        endcase
    endfunction

    // Each mode bit enables a pair of key pins
    function automatic logic [NKEY-1:0] key_mask(input logic [3:0] m);
        logic [NKEY-1:0] k;
        k = '0;
        for (int i = 0; i < NKEY; i++)
            k[i] = m[(i / 2) % 4];
        return k;
    endfunction

    function automatic logic vec_pending(input logic [2:0]         v,
                                         input logic [NUM_SRC-1:0] p);
        case (v)
            VEC_BT4:  vec_pending = p[SRC_BT] | p[SRC_EXT4];
            VEC_EXT0: vec_pending = p[SRC_EXT0];
            VEC_EXT1: vec_pending = p[SRC_EXT1];
            VEC_CSI:  vec_pending = p[SRC_CSI];
            VEC_T0:   vec_pending = p[SRC_T0];
            VEC_TPG:  vec_pending = p[SRC_TPG];
            default:  vec_pending = 1'b0;
        endcase
    endfunction

    function automatic logic [NUM_SRC-1:0] accept_clear(
        input logic [2:0]         v,
        input logic [NUM_SRC-1:0] ie);
        logic [NUM_SRC-1:0] m;
        m = '0;
        case (v)
            VEC_BT4:
            begin
                if (!(ie[SRC_BT] && ie[SRC_EXT4]))
                begin
                    m[SRC_BT]   = ie[SRC_BT];
                    m[SRC_EXT4] = ie[SRC_EXT4];
                end
            end
            VEC_EXT0: m[SRC_EXT0] = 1'b1;
            VEC_EXT1: m[SRC_EXT1] = 1'b1;
            VEC_CSI:  m[SRC_CSI]  = 1'b1;
            VEC_T0:   m[SRC_T0]   = 1'b1;
            VEC_TPG:  m[SRC_TPG]  = 1'b1;
            default:  m = '0;
        endcase
        return m;
    endfunction

    // Sampling stops in standby, so ext0 edges there are seen only once sampling resumes
    // clock select, standby gate
    assign flt_if.sample_tick = (s_q.im0[IM0_SCLK_BIT] ? fx_div64_tick_i
                                                       : cpu_clk_tick_i)
                                & ~standby_i;
    assign flt_if.raw         = ext_irq_pin0_i;

    logic [NUM_SRC-1:0] hw_set;
    logic               key_all_high;
    logic               key_mode;
    logic [NUM_SRC-1:0] pend;
    logic [2:0]         sel;

    always_comb
    begin
        s_d          = s_q;
        hw_set       = '0;
        pend         = '0;
        sel          = VEC_NONE;
        key_mode     = s_q.im2 != IM_RST;
        key_all_high = &(key_input_i | ~key_mask(s_q.im2));

        hw_set[SRC_BT]  = bt_tick_i;
        hw_set[SRC_CSI] = serial_done_i;
        hw_set[SRC_T0]  = timer_match_i;
        hw_set[SRC_TPG] = pulse_gen_match_i;
        hw_set[SRC_W]   = watch_tick_i;
        hw_set[SRC_EXT4] = edge_hit(EDGE_BOTH, s_q.ext4_prev,
                                    ext_irq_pin4_i);
        hw_set[SRC_EXT0] = edge_hit(s_q.im0[1:0], s_q.ext0_prev,
                                    flt_if.clean);
        hw_set[SRC_EXT1] = edge_hit({1'b0, s_q.im1[0]}, s_q.ext1_prev,
                                    ext_irq_pin1_i);
        if (key_mode)
            hw_set[SRC_EXT2] = s_q.key_prev & ~key_all_high;
        else
            hw_set[SRC_EXT2] = ext_irq_pin2_i & ~s_q.ext2_prev;

        s_d.ext0_prev = flt_if.clean;
        s_d.ext1_prev = ext_irq_pin1_i;
        s_d.ext2_prev = ext_irq_pin2_i;
        s_d.ext4_prev = ext_irq_pin4_i;
        s_d.key_prev  = key_all_high;

        if (nib_wr_i)
        begin
            for (int i = 0; i < NUM_SRC; i++)
            begin
                if (nib_addr_i == NIB_IRQ_BASE + 4'(i / 4))
                    s_d.irq[i] = nib_wdata_i[i % 4];
                if (nib_addr_i == NIB_IE_BASE + 4'(i / 4))
                    s_d.ie[i] = nib_wdata_i[i % 4];
            end
            case (nib_addr_i)
                NIB_IM0: s_d.im0 = nib_wdata_i;
                NIB_IM1: s_d.im1 = nib_wdata_i;
                NIB_IM2: s_d.im2 = nib_wdata_i;
                NIB_IPS: s_d.interrupt_priority_select = nib_wdata_i;
                default: s_d.interrupt_priority_select = s_d.interrupt_priority_select;
            endcase
        end

        if (nib_rd_i)
        begin
            s_d.rdata = 4'h0;
            for (int i = 0; i < NUM_SRC; i++)
            begin
                if (nib_addr_i == NIB_IRQ_BASE + 4'(i / 4))
                    s_d.rdata[i % 4] = s_q.irq[i];
                if (nib_addr_i == NIB_IE_BASE + 4'(i / 4))
                    s_d.rdata[i % 4] = s_q.ie[i];
            end
            case (nib_addr_i)
                NIB_IM0: s_d.rdata = s_q.im0;
                NIB_IM1: s_d.rdata = s_q.im1;
                NIB_IM2: s_d.rdata = s_q.im2;
                NIB_IPS: s_d.rdata = s_q.interrupt_priority_select;
                default: s_d.rdata = s_d.rdata;
            endcase
        end

        if (bit_op_valid_i)
        begin
            s_d.skip = 1'b0;
            for (int i = 0; i < NUM_SRC; i++)
            begin
                if (bit_addr_i == 5'(i))
                begin
                    s_d.bit_val = s_q.irq[i];
                    case (bit_op_i)
                        BOP_SET:  s_d.irq[i] = 1'b1;
                        BOP_CLR:  s_d.irq[i] = 1'b0;
                        BOP_TCLR:
                        begin
                            s_d.skip   = s_q.irq[i];
                            s_d.irq[i] = 1'b0;
                        end
                        BOP_TEST: s_d.skip = s_q.irq[i];
                        default:  s_d.skip = 1'b0;
                    endcase
                end
                if (bit_addr_i == BIT_IE_BASE + 5'(i))
                begin
                    s_d.bit_val = s_q.ie[i];
                    case (bit_op_i)
                        BOP_SET:  s_d.ie[i] = 1'b1;
                        BOP_CLR:  s_d.ie[i] = 1'b0;
                        BOP_TCLR:
                        begin
                            s_d.skip  = s_q.ie[i];
                            s_d.ie[i] = 1'b0;
                        end
                        BOP_TEST: s_d.skip = s_q.ie[i];
                        default:  s_d.skip = 1'b0;
                    endcase
                end
            end
        end

        if (global_enable_op_i)
            s_d.interrupt_priority_select[IPS_IME_BIT] = 1'b1;
        else if (global_disable_op_i)
            s_d.interrupt_priority_select[IPS_IME_BIT] = 1'b0;

        if (irq_accept_i)
            s_d.irq = s_d.irq & ~accept_clear(s_q.vec, s_q.ie);

        s_d.irq = s_d.irq | hw_set;

        pend = s_d.irq & s_d.ie;
        s_d.wake = |pend;

        for (int v = VEC_LAST; v >= 1; v--)
        begin
            if (vec_pending(3'(v), pend) &&
                (nest_status_i == 2'h0 ||
                 (nest_status_i == 2'h1 && s_d.interrupt_priority_select[2:0] == 3'(v))))
                sel = 3'(v);
        end
        if (!s_d.interrupt_priority_select[IPS_IME_BIT])
            sel = VEC_NONE;
        s_d.vec     = sel;
        s_d.vec_req = sel != VEC_NONE;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            s_q <= '0;
        else if (ce_i)
            s_q <= s_d;
    end

    assign bit_value_o         = s_q.bit_val;
    assign skip_o              = s_q.skip;
    assign nib_rdata_o         = s_q.rdata;
    assign vectored_request_o  = s_q.vec_req;
    assign vector_num_o        = s_q.vec;
    assign wake_o              = s_q.wake;
    assign master_irq_enable_o = s_q.interrupt_priority_select[IPS_IME_BIT];

endmodule // irq_request_enable

//--- test/irq_request_enable_sva.sv
// Purpose: Port-level checks for irq_request_enable
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Flags are internal, so checks tie outputs to their causes
`timescale 1ns/1ps
module irq_request_enable_sva
    import irq_ctrl_pkg::*;
(
    // Clock, reset, enable
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    // CPU sequencer and bit port
    input  wire logic [1:0] nest_status_i,
    input  wire logic       global_enable_op_i,
    input  wire logic       global_disable_op_i,
    input  wire logic       bit_op_valid_i,
    input  wire bit_op_e    bit_op_i,
    input  wire logic       nib_rd_i,
    // Outputs watched
    input  wire logic       bit_value_o,
    input  wire logic       skip_o,
    input  wire logic [3:0] nib_rdata_o,
    input  wire logic       vectored_request_o,
    input  wire logic [2:0] vector_num_o,
    input  wire logic       wake_o,
    input  wire logic       master_irq_enable_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_ei;
        ce_i && global_enable_op_i;
    endsequence
    sequence s_di;
        ce_i && global_disable_op_i && !global_enable_op_i;
    endsequence
    sequence s_ime_off;
        !master_irq_enable_o && !$past(master_irq_enable_o);
    endsequence

    a_ei_sets_ime: assert property (s_ei |=> master_irq_enable_o)
        else $error("master enable not set by enable op");
    a_di_clears_ime: assert property (s_di |=> !master_irq_enable_o)
        else $error("master enable not cleared by disable op");
    a_ime_gates_req: assert property (s_ime_off |-> !vectored_request_o)
        else $error("request while master enable off");
    a_req_wakes: assert property (
        vectored_request_o && $past(vectored_request_o) |-> wake_o)
        else $error("request without wake");
    a_status2_blocks: assert property (
        ce_i && nest_status_i[1] |=> !vectored_request_o)
        else $error("request in status 2");
    a_vec_range: assert property (
        vectored_request_o |-> vector_num_o inside {[3'h1:3'h6]})
        else $error("vector number out of range");
    a_skip_means_one: assert property (skip_o |-> bit_value_o)
        else $error("skip without flag set");
    a_no_skip_setclr: assert property (
        ce_i && bit_op_valid_i && (bit_op_i == BOP_SET ||
        bit_op_i == BOP_CLR) |=> !skip_o)
        else $error("skip after set or clear");
    a_rdata_holds: assert property (
        ce_i && !nib_rd_i |=> $stable(nib_rdata_o))
        else $error("read data moved without read");
    a_reset_quiet: assert property ($rose(rst_n_i) |->
        !vectored_request_o && !wake_o && !master_irq_enable_o)
        else $error("outputs active after reset");
endmodule // irq_request_enable_sva

bind irq_request_enable irq_request_enable_sva u_sva (
    .clk_sys_i, .rst_n_i, .ce_i, .nest_status_i, .global_enable_op_i,
    .global_disable_op_i, .bit_op_valid_i, .bit_op_i, .nib_rd_i,
    .bit_value_o, .skip_o, .nib_rdata_o, .vectored_request_o,
    .vector_num_o, .wake_o, .master_irq_enable_o);

//--- test/cpu_accept_model.sv
// Purpose: CPU sequencer stand-in that accepts vectored requests
// Assumes: Bench arms it for each acceptance it wants
// Notes:   Accepts only a request that stands for lat_i+1 cycles
`timescale 1ns/1ps
module cpu_accept_model
(
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    // Bench control
    input  wire logic       arm_i,
    input  wire logic [3:0] lat_i,
    // Request side
    input  wire logic       vectored_request_i,
    output logic            irq_accept_o
);
    logic [3:0] wait_q;

    // A withdrawn request restarts the count, as a real core would
    // Samples on the rising edge so the bench's falling-edge arm is settled
    always @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wait_q       <= 4'h0;
            irq_accept_o <= 1'b0;
        end
        else
        begin
            irq_accept_o <= 1'b0;
            if (!arm_i || !vectored_request_i)
                wait_q <= 4'h0;
            else if (wait_q == lat_i && !irq_accept_o)
                irq_accept_o <= 1'b1;
            else if (wait_q != lat_i)
                wait_q <= wait_q + 4'h1;
        end
    end
endmodule // cpu_accept_model

//--- test/irq_request_enable_tb_top.sv
// Purpose: Self-checking bench for irq_request_enable
// Assumes: Inputs change on the falling edge of clk_sys_i
// Notes:   Flags are observed through the bit and nibble ports
`timescale 1ns/1ps
module irq_request_enable_tb_top;
    import irq_ctrl_pkg::*;
    logic       clk_sys_i = 1'b0;
    logic       rst_n_i   = 1'b0;
    logic       ce_i      = 1'b1;
    logic [4:0] ev        = 5'h0;
    logic       pin0 = 1'b0, pin1 = 1'b0, pin2 = 1'b0, pin4 = 1'b0;
    logic [7:0] keys      = 8'hff;
    logic       fx_tick   = 1'b0, standby = 1'b0;
    logic [1:0] status    = 2'h0;
    logic       ei = 1'b0, di = 1'b0, arm = 1'b0;
    logic [3:0] lat       = 4'h0;
    logic       bv        = 1'b0;
    bit_op_e    bop       = BOP_TEST;
    logic [4:0] badr      = 5'h0;
    logic       nwr = 1'b0, nrd = 1'b0;
    logic [3:0] nadr = 4'h0, nwd = 4'h0;
    logic       bval, skip, vreq, wake, master_irq_enable, acc;
    logic [3:0] rdata;
    logic [2:0] vnum;
    int         err_count       = 0;
    int         samples_checked = 0;

    always #25 clk_sys_i = ~clk_sys_i;

    irq_request_enable u_dut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .bt_tick_i(ev[0]), .serial_done_i(ev[1]), .timer_match_i(ev[2]),
        .pulse_gen_match_i(ev[3]), .watch_tick_i(ev[4]),
        .ext_irq_pin0_i(pin0), .ext_irq_pin1_i(pin1),
        .ext_irq_pin2_i(pin2), .ext_irq_pin4_i(pin4),
        .key_input_i(keys), .cpu_clk_tick_i(1'b1),
        .fx_div64_tick_i(fx_tick), .standby_i(standby),
        .nest_status_i(status), .global_enable_op_i(ei),
        .global_disable_op_i(di), .irq_accept_i(acc),
        .bit_op_valid_i(bv), .bit_op_i(bop), .bit_addr_i(badr),
        .bit_value_o(bval), .skip_o(skip), .nib_wr_i(nwr),
        .nib_rd_i(nrd), .nib_addr_i(nadr), .nib_wdata_i(nwd),
        .nib_rdata_o(rdata), .vectored_request_o(vreq),
        .vector_num_o(vnum), .wake_o(wake), .master_irq_enable_o(master_irq_enable));

    cpu_accept_model u_cpu (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .arm_i(arm),
        .lat_i(lat), .vectored_request_i(vreq), .irq_accept_o(acc));

    task automatic end_of_test();
        if (err_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask

    task automatic bit_do(input bit_op_e op, input logic [4:0] a);
        bv   = 1'b1;
        bop  = op;
        badr = a;
        cyc(1);
        bv = 1'b0;
    endtask

    task automatic flag(input int src, input logic e);
        bit_do(BOP_TEST, 5'(src));
        chk(4'(bval), 4'(e));
    endtask

    task automatic nib_wr(input logic [3:0] a, input logic [3:0] d);
        nwr  = 1'b1;
        nadr = a;
        nwd  = d;
        cyc(1);
        nwr = 1'b0;
    endtask

    task automatic nib_rd(input logic [3:0] a, input logic [3:0] e);
        nrd  = 1'b1;
        nadr = a;
        cyc(1);
        nrd = 1'b0;
        chk(rdata, e);
    endtask

    task automatic pulse(input int i);
        ev[i] = 1'b1;
        cyc(1);
        ev = 5'h0;
    endtask

    task automatic accept(input logic [3:0] l);
        int i;
        lat = l;
        arm = 1'b1;
        for (i = 0; i < 40 && acc !== 1'b1; i++)
            @(posedge clk_sys_i);
        cyc(1);
        arm = 1'b0;
        if (i == 40)
        begin
            err_count++;
            end_of_test();
        end
    endtask

    task automatic t_reset();
        logic [3:0] a [11] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6,
                               4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
        foreach (a[i]) nib_rd(a[i], 4'h0);
        chk({master_irq_enable, vreq, wake}, 4'h0);
    endtask

    task automatic t_serial();
        bit_do(BOP_SET, BIT_IE_BASE + 5'(SRC_CSI));
        nib_wr(NIB_IPS, 4'h8);
        chk(4'(master_irq_enable), 4'h1);
        pulse(1);
        chk({vreq, vnum}, {1'b1, VEC_CSI});
        chk(4'(wake), 4'h1);
        accept(4'h0);
        chk(4'(vreq), 4'h0);
        flag(SRC_CSI, 1'b0);
        di = 1'b1;
        cyc(1);
        di = 1'b0;
        bit_do(BOP_SET, 5'(SRC_CSI));
        chk({master_irq_enable, vreq, wake}, 4'h1);
        ei = 1'b1;
        cyc(1);
        ei = 1'b0;
        cyc(1);
        chk({vreq, vnum}, {1'b1, VEC_CSI});
        accept(4'h3);
        flag(SRC_CSI, 1'b0);
    endtask

    task automatic t_sources();
        int idx [5] = '{SRC_BT, SRC_CSI, SRC_T0, SRC_TPG, SRC_W};
        foreach (idx[i])
        begin
            pulse(i);
            bit_do(BOP_TCLR, 5'(idx[i]));
            chk({skip, bval}, 4'h3);
            bit_do(BOP_TEST, 5'(idx[i]));
            chk({skip, bval}, 4'h0);
        end
    endtask

    task automatic t_priority();
        bit_do(BOP_SET, BIT_IE_BASE + 5'(SRC_TPG));
        bit_do(BOP_SET, 5'(SRC_TPG));
        bit_do(BOP_SET, 5'(SRC_CSI));
        chk({vreq, vnum}, {1'b1, VEC_CSI});
        nib_rd(NIB_IRQ_BASE + 4'h1, 4'h5);
        nib_rd(NIB_IE_BASE + 4'h1, 4'h5);
        nib_wr(NIB_IPS, 4'he);
        status = 2'h1;
        cyc(2);
        chk({vreq, vnum}, {1'b1, VEC_TPG});
        status = 2'h2;
        cyc(2);
        chk(4'(vreq), 4'h0);
        status = 2'h0;
        nib_wr(NIB_IPS, 4'h8);
        nib_wr(NIB_IRQ_BASE + 4'h1, 4'h0);
        cyc(1);
        chk(4'(vreq), 4'h0);
    endtask

    task automatic t_shared();
        bit_do(BOP_SET, BIT_IE_BASE + 5'(SRC_BT));
        bit_do(BOP_SET, BIT_IE_BASE + 5'(SRC_EXT4));
        bit_do(BOP_SET, 5'(SRC_BT));
        chk({vreq, vnum}, {1'b1, VEC_BT4});
        accept(4'h0);
        flag(SRC_BT, 1'b1);
        bit_do(BOP_CLR, BIT_IE_BASE + 5'(SRC_EXT4));
        accept(4'h1);
        flag(SRC_BT, 1'b0);
    endtask

    task automatic t_pins();
        pin4 = 1'b1;
        cyc(3);
        bit_do(BOP_TCLR, 5'(SRC_EXT4));
        chk(4'(skip), 4'h1);
        pin4 = 1'b0;
        cyc(3);
        bit_do(BOP_TCLR, 5'(SRC_EXT4));
        chk(4'(skip), 4'h1);
        pin0 = 1'b1;
        cyc(1);
        pin0 = 1'b0;
        cyc(6);
        flag(SRC_EXT0, 1'b0);
        pin0 = 1'b1;
        cyc(6);
        flag(SRC_EXT0, 1'b1);
        // Clear after each mode change: the flag set by the previous edge is still pending
        nib_wr(NIB_IM0, {2'h0, EDGE_FALL});
        cyc(6);
        bit_do(BOP_CLR, 5'(SRC_EXT0));
        pin0 = 1'b0;
        cyc(6);
        flag(SRC_EXT0, 1'b1);
        nib_wr(NIB_IM0, 4'h8);
        cyc(4);
        bit_do(BOP_CLR, 5'(SRC_EXT0));
        standby = 1'b1;
        pin0    = 1'b1;
        // Ticks arrive in standby but must not reach the filter
        repeat (3)
        begin
            fx_tick = 1'b1;
            cyc(1);
            fx_tick = 1'b0;
            cyc(1);
        end
        flag(SRC_EXT0, 1'b0);
        standby = 1'b0;
        cyc(6);
        flag(SRC_EXT0, 1'b0);
        repeat (4)
        begin
            fx_tick = 1'b1;
            cyc(1);
            fx_tick = 1'b0;
            cyc(2);
        end
        flag(SRC_EXT0, 1'b1);
    endtask

    task automatic t_ext2();
        pin1 = 1'b1;
        cyc(2);
        flag(SRC_EXT1, 1'b1);
        nib_wr(NIB_IM1, 4'h1);
        bit_do(BOP_CLR, 5'(SRC_EXT1));
        pin1 = 1'b0;
        cyc(2);
        flag(SRC_EXT1, 1'b1);
        pin2 = 1'b1;
        cyc(3);
        flag(SRC_EXT2, 1'b1);
        nib_wr(NIB_IM2, 4'h1);
        cyc(2);
        bit_do(BOP_CLR, 5'(SRC_EXT2));
        keys[1] = 1'b0;
        cyc(3);
        flag(SRC_EXT2, 1'b1);
        bit_do(BOP_CLR, 5'(SRC_EXT2));
        keys[0] = 1'b0;
        keys[5] = 1'b0;
        cyc(3);
        flag(SRC_EXT2, 1'b0);
    endtask

    task automatic t_race();
        ev[1] = 1'b1;
        bit_do(BOP_CLR, 5'(SRC_CSI));
        ev = 5'h0;
        flag(SRC_CSI, 1'b1);
        bit_do(BOP_SET, 5'(SRC_T0));
        // Idle pins first: a high pin at release reads as a rising edge
        pin0    = 1'b0;
        pin2    = 1'b0;
        keys    = 8'hff;
        rst_n_i = 1'b0;
        cyc(2);
        rst_n_i = 1'b1;
        cyc(1);
        t_reset();
    endtask

    initial
    begin
        #1000000;
        err_count++;
        end_of_test();
    end

    initial
    begin
        cyc(6);
        rst_n_i = 1'b1;
        cyc(1);
        t_reset();
        t_serial();
        t_sources();
        t_priority();
        t_shared();
        t_pins();
        t_ext2();
        t_race();
        end_of_test();
    end
endmodule // irq_request_enable_tb_top
